// ===== shared/sdma_consts.vh
/*
 * Constants of the stretched data memory access block: special function
 * register addresses, field positions, reset values, command codes and
 * machine cycle timing.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef SDMA_CONSTS_VH
`define SDMA_CONSTS_VH

// ------------------------------------------------------------------
// Special function register addresses
// ------------------------------------------------------------------
`define SDMA_ADDR_PTR0_LOW   8'h82
`define SDMA_ADDR_PTR0_HIGH  8'h83
`define SDMA_ADDR_PTR1_LOW   8'h84
`define SDMA_ADDR_PTR1_HIGH  8'h85
`define SDMA_ADDR_PTR_SELECT 8'h86
`define SDMA_ADDR_CLOCK_CTRL 8'h8E

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define SDMA_STRETCH_MSB     2
`define SDMA_STRETCH_LSB     0
`define SDMA_TIMER_MSB       5
`define SDMA_TIMER_LSB       3
`define SDMA_SELECT_BIT      0
`define SDMA_CLOCK_CTRL_RST  8'h01
`define SDMA_PTR_SELECT_RST  8'h00
`define SDMA_PTR_RST         16'h0000

// ------------------------------------------------------------------
// Sequencer command codes
// ------------------------------------------------------------------
`define SDMA_OP_FETCH        3'h0
`define SDMA_OP_READ         3'h1
`define SDMA_OP_WRITE        3'h2
`define SDMA_OP_INC          3'h3
`define SDMA_OP_LOAD         3'h4

// ------------------------------------------------------------------
// Machine cycle timing, in core clocks except the base move length, in machine cycles
// ------------------------------------------------------------------
`define SDMA_MCYCLE_CLKS     4
`define SDMA_PHASE_LAST      2'h3
`define SDMA_BASE_MCYCLES    2
`define SDMA_FAST_STROBE     2
`define SDMA_FAST_START      6'h05
`define SDMA_SLOW_START      6'h04
`define SDMA_ADDR_CLKS       6'h02

`endif

// ===== core/sdma_mcycle.v
/*
 * Machine cycle phase generator: a free running four-clock phase count
 * and one address latch enable pulse per machine cycle.
 * Assumes one core clock and an asynchronous active low reset.
 */
`timescale 1ns/10ps
`include "sdma_consts.vh"

module sdma_mcycle (
  input  wire       clk,    // Core clock
  input  wire       rst_n,  // Asynchronous reset, active low
  output reg  [1:0] phase,  // Clock within the machine cycle
  output reg        ale     // Address latch enable, high in phase 0
);

  // ------------------------------------------------------------------
  // Phase count and latch enable
  // ------------------------------------------------------------------

  // Four clocks per machine cycle, ALE once per cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      ale   <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      ale   <= (phase == `SDMA_PHASE_LAST);
    end
  end

endmodule // sdma_mcycle

// ===== core/sdma_core.v
/*
 * Stretched data memory access core: external bus sequencing for program
 * fetches and external data moves, dual data pointers, pointer select and
 * clock control registers on the special function register port.
 * Assumes a sequencer on the same clock issuing one command at a time,
 * an external latch on the address low byte and pins resolved outside.
 */
`timescale 1ns/10ps
`include "sdma_consts.vh"

module sdma_core (
  input  wire        clk,         // Core clock
  input  wire        rst_n,       // Asynchronous reset, active low
  // Special function register port
  input  wire [7:0]  sfr_addr,    // Register address
  input  wire        sfr_wr,      // Write strobe
  input  wire        sfr_rd,      // Read strobe
  input  wire [7:0]  sfr_wdata,   // Write data
  output reg  [7:0]  sfr_rdata,   // Read data, one clock after sfr_rd
  // Sequencer command port
  input  wire        cmd_valid,   // Command offered
  input  wire [2:0]  cmd_op,      // Command code
  input  wire [15:0] cmd_addr,    // Fetch address or pointer load value
  input  wire [7:0]  cmd_wdata,   // Write data of a data move
  output reg         cmd_ready,   // Command taken in this clock if valid
  output reg  [7:0]  rd_data,     // Byte read from the bus
  output reg         rd_valid,    // Pulse: rd_data is new
  output reg         rd_code,     // rd_data came from a program fetch
  output reg         busy,        // Bus cycle in progress
  // External bus pins
  input  wire [7:0]  port0_in,    // Port 0 pin levels
  output reg  [7:0]  port0_out,   // Port 0 drive value
  output reg         port0_oe,    // Port 0 output enable
  output reg  [7:0]  port2_out,   // High address byte
  output reg         ale,         // Address latch enable
  output reg         psen_n,      // Program store enable, active low
  output reg         rd_n,        // Data read strobe, active low
  output reg         wr_n         // Data write strobe, active low
);

  // ------------------------------------------------------------------
  // States and declarations
  // ------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_FETCH = 2'h1;
  localparam [1:0] ST_MOVE  = 2'h2;
  localparam [7:0] CLOCK_CTRL_RST = `SDMA_CLOCK_CTRL_RST;
  localparam [7:0] PTR_SELECT_RST = `SDMA_PTR_SELECT_RST;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [5:0]  cnt;
  reg  [2:0]  move_stretch;
  reg         move_write;
  reg  [7:0]  move_data;
  reg  [15:0] bus_addr;
  reg  [15:0] ptr0;
  reg  [15:0] ptr1;
  reg         ptr_sel;
  reg  [2:0]  stretch;
  reg  [2:0]  timer_bits;
  reg  [7:0]  p0_sync1;
  reg  [7:0]  p0_sync2;
  reg  [1:0]  rd_dly;
  reg  [1:0]  code_dly;
  wire [1:0]  phase;
  wire        ale_next;
  wire        take;
  wire [15:0] ptr_cur;
  wire [5:0]  strobe_first;
  wire [5:0]  strobe_last;
  wire [5:0]  move_last;
  wire [1:0]  start_state;
  wire        starting;
  reg         next_psen_n;
  reg         next_rd_n;
  reg         next_wr_n;
  reg  [7:0]  next_p0;
  reg         next_oe;

  // ------------------------------------------------------------------
  // Timing functions
  // ------------------------------------------------------------------

  // Length of a data move in clocks, minus one
  function [5:0] move_end;
    input [2:0] s;
    begin
      move_end = ({3'h0, s} + 6'd`SDMA_BASE_MCYCLES) * 6'd`SDMA_MCYCLE_CLKS - 6'h01;
    end
  endfunction

  // First clock of the read or write strobe
  function [5:0] strobe_start;
    input [2:0] s;
    begin
      strobe_start = (s == 3'h0) ? `SDMA_FAST_START : `SDMA_SLOW_START;
    end
  endfunction

  // Strobe width in clocks
  function [5:0] strobe_width;
    input [2:0] s;
    begin
      strobe_width = (s == 3'h0) ? 6'd`SDMA_FAST_STROBE
                                 : {3'h0, s} * 6'd`SDMA_MCYCLE_CLKS;
    end
  endfunction

  // ------------------------------------------------------------------
  // Machine cycle phase
  // ------------------------------------------------------------------

  // Four-clock phase and one latch pulse per cycle
  sdma_mcycle u_mcycle (
    .clk   (clk),
    .rst_n (rst_n),
    .phase (phase),
    .ale   (ale_next)
  );

  // Latch enable taken straight from the phase generator's flop
  always @* begin
    ale = ale_next;
  end

  // ------------------------------------------------------------------
  // Derived terms
  // ------------------------------------------------------------------

  // Selected pointer drives every pointer operation
  assign ptr_cur      = ptr_sel ? ptr1 : ptr0;
  assign take         = cmd_valid && cmd_ready;
  // Stretch frozen at the move's start sets all its timing
  assign strobe_first = strobe_start(move_stretch);
  assign strobe_last  = strobe_first + strobe_width(move_stretch) - 6'h01;
  assign move_last    = move_end(move_stretch);
  // Bus cycle a taken command opens; pointer commands open none
  assign start_state  = (cmd_op == `SDMA_OP_FETCH) ? ST_FETCH :
                        (cmd_op == `SDMA_OP_READ || cmd_op == `SDMA_OP_WRITE) ? ST_MOVE :
                        ST_IDLE;
  assign starting     = take && (start_state != ST_IDLE);

  // ------------------------------------------------------------------
  // Bus sequencer
  // ------------------------------------------------------------------

  // Next state: commands start on a machine cycle boundary
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = start_state;
        end
      end
      ST_FETCH: begin
        if (cnt == 6'd3) begin
          next_state = take ? start_state : ST_IDLE;
        end
      end
      ST_MOVE: begin
        if (cnt == move_last) begin
          next_state = take ? start_state : ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State, clock count within the bus cycle, captured move parameters
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      cnt          <= 6'h00;
      move_stretch <= 3'h1;
      move_write   <= 1'b0;
      move_data    <= 8'h00;
      bus_addr     <= 16'h0000;
      busy         <= 1'b0;
      cmd_ready    <= 1'b0;
    end else begin
      state     <= next_state;
      busy      <= (next_state != ST_IDLE);
      // Ready in the last phase of an idle or closing machine cycle
      cmd_ready <= (phase == 2'h2) &&
                   ((state == ST_IDLE) ||
                    (state == ST_FETCH && cnt == 6'd2) ||
                    (state == ST_MOVE && cnt + 6'h01 == move_last));
      if (next_state == ST_IDLE || starting) begin
        cnt <= 6'h00;
      end else begin
        cnt <= cnt + 6'h01;
      end
      if (starting) begin
        // Stretch sampled per move, so a rewrite affects later moves
        move_stretch <= stretch;
        move_write   <= (cmd_op == `SDMA_OP_WRITE);
        move_data    <= cmd_wdata;
        if (cmd_op == `SDMA_OP_FETCH) begin
          bus_addr <= cmd_addr;
        end else begin
          bus_addr <= ptr_cur;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin values
  // ------------------------------------------------------------------

  // Strobes and port 0 contents for the coming clock
  always @* begin
    next_psen_n = 1'b1;
    next_rd_n   = 1'b1;
    next_wr_n   = 1'b1;
    next_p0     = port0_out;
    next_oe     = 1'b0;
    case (next_state)
      ST_FETCH: begin
        // Fixed four-clock fetch, independent of the stretch
        if (starting) begin
          next_p0 = cmd_addr[7:0];
          next_oe = 1'b1;
        end else if (cnt == 6'h00) begin
          next_oe = 1'b1;
        end else begin
          next_psen_n = 1'b0;
        end
      end
      ST_MOVE: begin
        if (starting) begin
          next_p0 = ptr_cur[7:0];
          next_oe = 1'b1;
        end else if (cnt + 6'h01 < `SDMA_ADDR_CLKS) begin
          next_oe = 1'b1;
        end else begin
          // Write data held through the move, past the strobe's end
          next_p0 = move_write ? move_data : port0_out;
          next_oe = move_write;
          if (cnt + 6'h01 >= strobe_first &&
              cnt + 6'h01 <= strobe_last) begin
            next_rd_n = move_write;
            next_wr_n = !move_write;
          end
        end
      end
      default: begin
        next_psen_n = 1'b1;
      end
    endcase
  end

  // Registered pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_out <= 8'h00;
      port0_oe  <= 1'b0;
      port2_out <= 8'h00;
      psen_n    <= 1'b1;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
    end else begin
      port0_out <= next_p0;
      port0_oe  <= next_oe;
      psen_n    <= next_psen_n;
      rd_n      <= next_rd_n;
      wr_n      <= next_wr_n;
      // High address steady for the whole bus cycle
      if (starting && start_state == ST_FETCH) begin
        port2_out <= cmd_addr[15:8];
      end else if (starting) begin
        port2_out <= ptr_cur[15:8];
      end
    end
  end

  // ------------------------------------------------------------------
  // Read data capture
  // ------------------------------------------------------------------

  // Port 0 synchroniser and strobe delay of equal depth
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_sync1 <= 8'h00;
      p0_sync2 <= 8'h00;
      rd_dly   <= 2'h0;
      code_dly <= 2'h0;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
      rd_code  <= 1'b0;
    end else begin
      p0_sync1 <= port0_in;
      p0_sync2 <= p0_sync1;
      rd_dly   <= {rd_dly[0], !rd_n || !psen_n};
      code_dly <= {code_dly[0], !psen_n};
      // Last strobe clock's value survives, flagged as the strobe ends
      if (rd_dly[1]) begin
        rd_data <= p0_sync2;
        rd_code <= code_dly[1];
      end
      rd_valid <= rd_dly[1] && !rd_dly[0];
    end
  end

  // ------------------------------------------------------------------
  // Data pointers and control registers
  // ------------------------------------------------------------------

  // Pointers: sequencer increments and loads act on the selected one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr0 <= `SDMA_PTR_RST;
      ptr1 <= `SDMA_PTR_RST;
    end else begin
      if (sfr_wr && sfr_addr == `SDMA_ADDR_PTR0_LOW) begin
        ptr0[7:0] <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == `SDMA_ADDR_PTR0_HIGH) begin
        ptr0[15:8] <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == `SDMA_ADDR_PTR1_LOW) begin
        ptr1[7:0] <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == `SDMA_ADDR_PTR1_HIGH) begin
        ptr1[15:8] <= sfr_wdata;
      end
      // Sequencer pointer operation wins over a register write
      if (take && cmd_op == `SDMA_OP_INC) begin
        if (ptr_sel) begin
          ptr1 <= ptr1 + 16'h0001;
        end else begin
          ptr0 <= ptr0 + 16'h0001;
        end
      end else if (take && cmd_op == `SDMA_OP_LOAD) begin
        if (ptr_sel) begin
          ptr1 <= cmd_addr;
        end else begin
          ptr0 <= cmd_addr;
        end
      end
    end
  end

  // Select bit and clock control fields
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_sel    <= PTR_SELECT_RST[`SDMA_SELECT_BIT];
      stretch    <= CLOCK_CTRL_RST[`SDMA_STRETCH_MSB:`SDMA_STRETCH_LSB];
      timer_bits <= 3'h0;
    end else begin
      // Only bit 0 is stored, so an increment just flips it
      if (sfr_wr && sfr_addr == `SDMA_ADDR_PTR_SELECT) begin
        ptr_sel <= sfr_wdata[`SDMA_SELECT_BIT];
      end
      if (sfr_wr && sfr_addr == `SDMA_ADDR_CLOCK_CTRL) begin
        stretch    <= sfr_wdata[`SDMA_STRETCH_MSB:`SDMA_STRETCH_LSB];
        timer_bits <= sfr_wdata[`SDMA_TIMER_MSB:`SDMA_TIMER_LSB];
      end
    end
  end

  // Register read port; unmapped addresses read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `SDMA_ADDR_PTR0_LOW:   sfr_rdata <= ptr0[7:0];
        `SDMA_ADDR_PTR0_HIGH:  sfr_rdata <= ptr0[15:8];
        `SDMA_ADDR_PTR1_LOW:   sfr_rdata <= ptr1[7:0];
        `SDMA_ADDR_PTR1_HIGH:  sfr_rdata <= ptr1[15:8];
        `SDMA_ADDR_PTR_SELECT: sfr_rdata <= {7'h00, ptr_sel};
        `SDMA_ADDR_CLOCK_CTRL: sfr_rdata <= {2'h0, timer_bits, stretch};
        default:               sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule // sdma_core

// ===== verification/sdma_core_props.sv
/* Checker of the external bus timing and register rules of sdma_core.
   Bound to sdma_core; needs the shared constants header. */
`timescale 1ns/10ps
`include "sdma_consts.vh"

module sdma_core_props (
  input wire        clk,        // Clock
  input wire        rst_n,      // Reset
  input wire [7:0]  sfr_addr,   // Reg address
  input wire        sfr_wr,     // Reg write
  input wire        sfr_rd,     // Reg read
  input wire [7:0]  sfr_wdata,  // Reg wdata
  input wire [7:0]  sfr_rdata,  // Reg rdata
  input wire        cmd_valid,  // Cmd valid
  input wire [2:0]  cmd_op,     // Cmd code
  input wire [15:0] cmd_addr,   // Cmd address
  input wire        cmd_ready,  // Cmd ready
  input wire [7:0]  port0_out,  // Port 0
  input wire        port0_oe,   // Port 0 enable
  input wire [7:0]  port2_out,  // Port 2
  input wire        ale,        // Latch enable
  input wire        psen_n,     // Fetch strobe
  input wire        rd_n,       // Read strobe
  input wire        wr_n        // Write strobe
);
  // ------------------------------------------------------------
  // Stretch shadow and strobe length
  // ------------------------------------------------------------
  reg  [2:0] shadow;
  reg  [2:0] cur;
  reg  [4:0] low_cnt;
  wire       take  = cmd_valid && cmd_ready;
  wire [4:0] exp_w = (cur == 3'h0) ? 5'h02 : {cur, 2'b00};

  // Follow stretch writes, latch at move take, count strobe clocks
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow  <= 3'h1;
      cur     <= 3'h1;
      low_cnt <= 5'h00;
    end else begin
      if (sfr_wr && sfr_addr == `SDMA_ADDR_CLOCK_CTRL)
        shadow <= sfr_wdata[2:0];
      if (take && (cmd_op == `SDMA_OP_READ || cmd_op == `SDMA_OP_WRITE))
        cur <= shadow;
      low_cnt <= (rd_n && wr_n) ? 5'h00 : low_cnt + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ale_once_a: assert property (ale |=> !ale [*3] ##1 ale)
    else $error("latch enable not once per four clocks");
  strobe_width_a: assert property (($rose(rd_n) || $rose(wr_n)) |-> low_cnt == exp_w)
    else $error("data strobe width wrong");
  fetch_width_a: assert property ($fell(psen_n) |=> !psen_n ##1 psen_n)
    else $error("fetch strobe width wrong");
  hold_stable_a: assert property ((!(rd_n && wr_n) && !$past(rd_n && wr_n)) |-> $stable(port2_out) && (wr_n || $stable(port0_out)))
    else $error("bus moved during strobe");
  write_drive_a: assert property (!wr_n |-> port0_oe)
    else $error("write data not driven");
  read_float_a: assert property (!(rd_n && psen_n) |-> !port0_oe)
    else $error("port 0 driven during read");
  fetch_addr_a: assert property ((take && cmd_op == `SDMA_OP_FETCH) |=> ale && port0_oe && {port2_out, port0_out} == $past(cmd_addr))
    else $error("fetch address wrong");
  ready_phase_a: assert property (cmd_ready |=> ale)
    else $error("ready outside last phase");
  select_zero_a: assert property ((sfr_rd && sfr_addr == `SDMA_ADDR_PTR_SELECT) |=> sfr_rdata[7:1] == 7'h00)
    else $error("select upper bits not zero");
endmodule // sdma_core_props

bind sdma_core sdma_core_props i_sdma_core_props (
  .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .port0_out(port0_out), .port0_oe(port0_oe),
  .port2_out(port2_out), .ale(ale), .psen_n(psen_n), .rd_n(rd_n), .wr_n(wr_n));

// ===== verification/sdma_ext_mem.sv
/* External memory model: address latch, data RAM and code pattern.
   Assumes the core's bus pins; drives the resolved port 0 level. */
`timescale 1ns/10ps

module sdma_ext_mem (
  input  wire       clk,        // Clock
  input  wire [7:0] port0_out,  // Core drive
  input  wire       port0_oe,   // Core enable
  input  wire [7:0] port2_out,  // High address
  input  wire       ale,        // Latch enable
  input  wire       psen_n,     // Fetch strobe
  input  wire       rd_n,       // Read strobe
  input  wire       wr_n,       // Write strobe
  input  wire [4:0] lag,        // Read clocks before valid
  output reg  [7:0] port0_in    // Port 0 level
);
  reg  [7:0]  mem [0:65535];
  reg  [7:0]  lat_lo = 8'h00;
  reg  [7:0]  last = 8'h00;
  reg  [4:0]  low_cnt = 5'h00;
  reg         armed = 1'b1;
  reg         was_low = 1'b0;
  wire [15:0] addr = {port2_out, lat_lo};

  // Latch low address at the first driven ALE of a new bus cycle only
  always @(posedge clk) begin
    if (ale && armed && port0_oe) begin
      lat_lo <= port0_out;
      armed  <= 1'b0;
    end else if (!psen_n || (was_low && rd_n && wr_n))
      armed <= 1'b1;
    was_low <= !(rd_n && wr_n);
    if (!wr_n)
      mem[addr] <= port0_out;
    low_cnt <= rd_n ? 5'h00 : low_cnt + 5'h01;
    last    <= port0_in;
  end

  // Slow reads answer after lag clocks; idle bus shows a moving pattern
  always @* begin
    if (port0_oe)
      port0_in = port0_out;
    else if (!psen_n)
      port0_in = addr[7:0] ^ addr[15:8] ^ 8'h5A;
    else if (!rd_n && low_cnt >= lag)
      port0_in = mem[addr];
    else
      port0_in = ~last;
  end
endmodule // sdma_ext_mem

// ===== verification/sdma_core_tb.sv
/* Self-checking bench of sdma_core with an external memory model.
   Assumes the checker is bound and the model answers on port 0. */
`timescale 1ns/10ps

module sdma_core_tb;
  reg         clk;
  reg         rst_n;
  reg  [7:0]  sfr_addr;
  reg         sfr_wr;
  reg         sfr_rd;
  reg  [7:0]  sfr_wdata;
  reg         cmd_valid;
  reg  [2:0]  cmd_op;
  reg  [15:0] cmd_addr;
  reg  [7:0]  cmd_wdata;
  reg  [4:0]  lag;
  wire [7:0]  sfr_rdata, rd_data, port0_in, port0_out, port2_out;
  wire        cmd_ready, rd_valid, rd_code, busy, port0_oe, ale, psen_n, rd_n, wr_n;
  integer     n_errors, n_compared, cyc, t_take, t_prev, s;
  reg  [31:0] rnd;
  reg  [15:0] p;
  reg  [7:0]  v, d, ra;
  reg         c;

  sdma_core i_sdma_core (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_code(rd_code), .busy(busy),
    .port0_in(port0_in), .port0_out(port0_out), .port0_oe(port0_oe), .port2_out(port2_out),
    .ale(ale), .psen_n(psen_n), .rd_n(rd_n), .wr_n(wr_n));
  sdma_ext_mem i_sdma_ext_mem (.clk(clk), .port0_out(port0_out), .port0_oe(port0_oe),
    .port2_out(port2_out), .ale(ale), .psen_n(psen_n), .rd_n(rd_n), .wr_n(wr_n),
    .lag(lag), .port0_in(port0_in));

  // ------------------------------------------------------------
  // Clock, cycle count, expectations
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y  = x ^ (x << 13);
      y  = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [4:0] strobe_w(input integer st);
    strobe_w = (st == 0) ? 5'h02 : 5'(4 * st);
  endfunction

  // ------------------------------------------------------------
  // Compare, report and bus tasks
  // ------------------------------------------------------------
  task chk_byte(input [7:0] e, input [7:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
    end
  endtask
  task chk_cnt(input integer e, input integer g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
    end
  endtask
  task stop_test;
    begin
      if (n_errors == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task tmo;
    begin
      n_errors = n_errors + 1;
      stop_test;
    end
  endtask
  task reg_wr(input [7:0] a, input [7:0] dv);
    begin
      @(posedge clk);
      sfr_addr  <= a;
      sfr_wdata <= dv;
      sfr_wr    <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
    end
  endtask
  task reg_rd(input [7:0] a, output [7:0] q);
    begin
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1 q = sfr_rdata;
    end
  endtask
  // Offer a command and hold it until the ready edge
  task cmd(input [2:0] op, input [15:0] a, input [7:0] wd);
    integer i;
    begin
      i = 0;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_op    <= op;
      cmd_addr  <= a;
      cmd_wdata <= wd;
      @(posedge clk);
      while (cmd_ready !== 1'b1 && i < 200) begin
        @(posedge clk);
        i = i + 1;
      end
      if (i == 200) tmo;
      t_prev = t_take;
      t_take = cyc;
      cmd_valid <= 1'b0;
    end
  endtask
  task wait_rd(output [7:0] q, output cq);
    integer i;
    begin
      i = 0;
      @(posedge clk);
      #1;
      while (rd_valid !== 1'b1 && i < 200) begin
        @(posedge clk);
        #1;
        i = i + 1;
      end
      if (i == 200) tmo;
      q  = rd_data;
      cq = rd_code;
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = 18'h0_0000;
    {cmd_valid, cmd_op, cmd_addr, cmd_wdata} = 28'h000_0000;
    lag = 5'h00;
    n_errors = 0;
    n_compared = 0;
    cyc = 0;
    t_take = 0;
    rnd = 32'h0000_000F;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unmapped read, pointer bytes
    reg_rd(8'h8E, v); chk_byte(8'h01, v);
    reg_rd(8'h86, v); chk_byte(8'h00, v);
    reg_rd(8'h81, v); chk_byte(8'h00, v);
    for (ra = 8'h82; ra <= 8'h85; ra = ra + 8'h01) begin
      rnd = xs(rnd);
      reg_rd(ra, v); chk_byte(8'h00, v);
      reg_wr(ra, rnd[7:0]);
      reg_rd(ra, v); chk_byte(rnd[7:0], v);
    end
    // Select: reserved bits and increment toggling
    reg_wr(8'h86, 8'hFF);
    reg_rd(8'h86, v); chk_byte(8'h01, v);
    reg_wr(8'h86, v + 8'h01);
    reg_rd(8'h86, v); chk_byte(8'h00, v);
    // Every stretch: load, write, fetch, slow read, increment
    for (s = 0; s < 8; s = s + 1) begin
      rnd = xs(rnd);
      p = rnd[23:8];
      d = rnd[31:24];
      reg_wr(8'h86, {7'h00, rnd[0]});
      reg_wr(8'h8E, {rnd[7:3], s[2:0]});
      reg_rd(8'h8E, v); chk_byte({2'b00, rnd[5:3], s[2:0]}, v);
      lag <= strobe_w(s) - 5'h01;
      cmd(3'h4, p, 8'h00);
      reg_rd(rnd[0] ? 8'h84 : 8'h82, v); chk_byte(p[7:0], v);
      cmd(3'h2, 16'h0000, d);
      cmd(3'h0, ~p, 8'h00); chk_cnt(4 * (s + 2), t_take - t_prev);
      wait_rd(v, c); chk_byte(p[7:0] ^ p[15:8] ^ 8'h5A, v);
      chk_byte(8'h01, {7'h00, c});
      cmd(3'h1, 16'h0000, 8'h00);
      wait_rd(v, c); chk_byte(d, v);
      chk_byte(8'h00, {7'h00, c});
      cmd(3'h3, 16'h0000, 8'h00);
      p = p + 16'h0001;
      reg_rd(rnd[0] ? 8'h84 : 8'h82, v); chk_byte(p[7:0], v);
      reg_rd(rnd[0] ? 8'h85 : 8'h83, v); chk_byte(p[15:8], v);
      cmd(3'h0, p, 8'h00);
      cmd(3'h0, ~p, 8'h00); chk_cnt(4, t_take - t_prev);
      @(posedge clk);
      #1 chk_byte(8'h01, {7'h00, busy});
      repeat (8) @(posedge clk);
      #1 chk_byte(8'h00, {7'h00, busy});
    end
    stop_test;
  end
endmodule // sdma_core_tb
